// ### hdl/wdt_cfg.svh
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// Register byte addresses, one aligned word each
`define WDT_ADDR_CONFIG     12'h000
`define WDT_ADDR_CONTROL    12'h004
`define WDT_ADDR_IRQ_STATUS 12'h008
`define WDT_ADDR_IRQ_MASK   12'h00C
`define WDT_ADDR_COUNT      12'h010

// Configuration word field positions
`define WDT_POSTSCALE_LSB   0
`define WDT_POSTSCALE_MSB   3
`define WDT_PRESCALE_BIT    4
`define WDT_ENABLE_LSB      5
`define WDT_ENABLE_MSB      6
`define WDT_WINDOW_DISABLE_BIT 7

// Control register field positions
`define WDT_SLEEP_BIT       3
`define WDT_IDLE_BIT        2
`define WDT_TIMEOUT_BIT     4
`define WDT_SWEN_BIT        5

// Reset values
`define WDT_CONFIG_RESET    8'hFF
`define WDT_MASK_RESET      2'h0

// Prescaler terminal counts, one less than the period in watchdog clock ticks
`define WDT_PRESCALE_SHORT  7'h1F
`define WDT_PRESCALE_LONG   7'h7F

// Watchdog clock source codes
`define WDT_SRC_RC_OSC      2'h0
`define WDT_SRC_SEC_OSC     2'h1
`define WDT_SRC_SYSTIMER    2'h2

`endif

// ### hdl/wdt_pkg.sv
package wdt_pkg;

  typedef enum logic [1:0] {
    EN_OFF   = 2'b00,
    EN_RSVD  = 2'b01,
    EN_SOFT  = 2'b10,
    EN_ON    = 2'b11
  } wdt_enable_mode_t;

  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_SLEEP = 2'b01,
    PM_IDLE  = 2'b10
  } power_mode_t;

  typedef struct packed {
    logic [2:0] sync;
  } sync_state_t;

endpackage : wdt_pkg

// ### hdl/wdt_tick_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; one pulse per agreed rising edge of the tick clock
module wdt_tick_sync (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      rise_pulse
);
  import wdt_pkg::*;

  sync_state_t st_q;
  sync_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Stage one feeds only stage two; edge taken from stages two and three
  always_comb begin
    st_d.sync = {st_q.sync[1:0], async_in};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rise_pulse = st_q.sync[1] & ~st_q.sync[2];

endmodule : wdt_tick_sync
`default_nettype wire

// ### hdl/wdt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdt_cfg.svh"

module wdt_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Watchdog clock inputs (asynchronous)
  input  wire logic        low_power_rc_clock,
  input  wire logic        secondary_oscillator,
  input  wire logic        system_timer_clock,
  // Core side
  input  wire logic        clear_watchdog_instr,
  input  wire logic        power_save_instr,
  input  wire logic        power_save_idle,
  input  wire logic        clock_switch_done,
  output logic             wake_request,
  output logic             device_reset_request,
  output logic             clock_source_enable,
  output logic [1:0]       clock_source_select,
  output logic             irq
);
  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, one aligned word each
  //   CONFIG     window disable, enable code, prescale length, postscale code
  //   CONTROL    software enable, time-out flag, Sleep and Idle flags,
  //              clock source select in the low two bits
  //   IRQ_STATUS wake and time-out events, cleared by a read of the register
  //   IRQ_MASK   same layout as IRQ_STATUS
  //   COUNT      read-only view of prescale and postscale counts
  // Unmapped or unaligned addresses answer with pslverr and read as zero
  //
  // Timing of one access
  //   Setup cycle, then the first access-phase edge registers read data and
  //   the ready pulse; writes land at the next edge, where the master sees
  //   ready high with the request still standing
  //
  // Time-out arithmetic
  //   A full period is (prescale length) x (2 ^ postscale code) source ticks;
  //   the time-out fires on the last tick of the last postscale step
  //
  // Hazards
  //   Source clocks are sampled, so each must run slower than half of clk_sys
  //   Config changes mid-count are caught by at-least compares, not equality
  //   Power mode only returns to run on a watchdog wake; no other wake input

  typedef struct packed {
    logic [7:0]   cfg;
    logic [1:0]   src_sel;
    logic         sw_en;
    logic         timeout_flag;
    logic         sleep_flag;
    logic         idle_flag;
    power_mode_t  pmode;
    logic [6:0]   pre_cnt;
    logic [15:0]  post_cnt;
    logic [1:0]   irq_stat;
    logic [1:0]   irq_mask;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         wake;
    logic         rst_req;
    logic         src_en;
    logic [1:0]   src_out;
    logic         irq;
  } wdt_state_t;

  wdt_state_t q;
  wdt_state_t d;

  logic rc_tick;
  logic sec_tick;
  logic stmr_tick;
  logic sel_tick;

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser per candidate clock source
  wdt_tick_sync u_sync_rc (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .async_in   (low_power_rc_clock),
    .rise_pulse (rc_tick)
  );
  wdt_tick_sync u_sync_sec (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .async_in   (secondary_oscillator),
    .rise_pulse (sec_tick)
  );
  wdt_tick_sync u_sync_stmr (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .async_in   (system_timer_clock),
    .rise_pulse (stmr_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Main next-state logic
  logic             access;
  logic             wr;
  logic             rd;
  wdt_enable_mode_t en_mode;
  logic             enabled;
  logic [6:0]       pre_max;
  logic [15:0]      post_max;
  logic             pre_wrap;
  logic             expire;
  logic             in_window;
  logic             restart;
  logic             early_clear;
  logic             in_save;
  logic             evt_timeout;
  logic             evt_wake;
  logic [1:0]       evt_vec;

  // Event summary for the next-state logic
  //   expire      last tick of the last postscale step while enabled
  //   early_clear clear instruction outside the window in windowed mode
  //   evt_timeout run-mode expiry or early clear; requests a device reset
  //   evt_wake    expiry in Sleep or Idle; wakes the core instead
  // Any restart source or event zeroes both counters in the same cycle,
  // so a clear and a tick in one cycle never leave a stale count

  always_comb begin
    d           = q;
    // Bus decode; a read clears status once, at the edge that captures it
    access      = psel & penable;
    // Writes land only at the edge where the master samples ready high
    wr          = access & pwrite & q.pready;
    rd          = access & ~pwrite & ~q.pready;

    // Enable decode from the configuration word
    en_mode     = wdt_enable_mode_t'(q.cfg[`WDT_ENABLE_MSB:`WDT_ENABLE_LSB]);
    // Code 01 is treated as off
    unique case (en_mode)
      EN_ON:   enabled = 1'b1;
      EN_SOFT: enabled = q.sw_en;
      EN_OFF:  enabled = 1'b0;
      EN_RSVD: enabled = 1'b0;
    endcase

    // Any power-save state counts as saving
    in_save     = (q.pmode != PM_RUN);
    // Sleep forces the RC oscillator
    // Idle keeps the selected source; only Sleep overrides it
    unique case (in_save && q.pmode == PM_SLEEP ? `WDT_SRC_RC_OSC : q.src_sel)
      `WDT_SRC_SEC_OSC:  sel_tick = sec_tick;
      `WDT_SRC_SYSTIMER: sel_tick = stmr_tick;
      default:           sel_tick = rc_tick;
    endcase
    // 32 or 128 ticks per prescaler period
    pre_max     = q.cfg[`WDT_PRESCALE_BIT] ? `WDT_PRESCALE_LONG : `WDT_PRESCALE_SHORT;
    // 2^code postscaler periods
    post_max    = 16'((17'h0_0001 << q.cfg[`WDT_POSTSCALE_MSB:`WDT_POSTSCALE_LSB]) - 17'h0_0001);
    // At-least compares: a shorter setting written mid-count still expires
    pre_wrap    = sel_tick & (q.pre_cnt >= pre_max);
    expire      = enabled & pre_wrap & (q.post_cnt >= post_max);
    // Last quarter of the period: post count past three quarters
    in_window   = ({2'b00, q.post_cnt} >= ((({2'b00, post_max} + 18'h0_0001) * 18'h0_0003) >> 2));
    early_clear = enabled & clear_watchdog_instr & ~in_save
                  & ~q.cfg[`WDT_WINDOW_DISABLE_BIT] & ~in_window;
    // Restart sources
    restart     = clock_switch_done | power_save_instr | clear_watchdog_instr
                  | ~enabled | q.wake;
    evt_timeout = (expire & ~in_save) | early_clear;
    evt_wake    = expire & in_save;

    // Counters; restarts include power-save entry and exit
    // Prescale wraps into one postscale step; both stay at zero while disabled
    if (restart || evt_timeout || evt_wake) begin
      d.pre_cnt  = '0;
      d.post_cnt = '0;
    end else if (enabled && sel_tick) begin
      if (pre_wrap) begin
        d.pre_cnt  = '0;
        d.post_cnt = q.post_cnt + 16'h0001;
      end else begin
        d.pre_cnt  = q.pre_cnt + 7'h01;
      end
    end

    // Power mode tracking
    // Entry latches Sleep or Idle from the level beside the pulse
    d.wake = evt_wake;
    if (evt_wake) begin
      d.pmode = PM_RUN;
    end else if (power_save_instr && !in_save) begin
      d.pmode = power_save_idle ? PM_IDLE : PM_SLEEP;
    end

    // Control register writes, then hardware sets win over clears
    // Time-out flag stays set until software writes it low; power-save entry sets one of Sleep and Idle and clears the other
    if (wr && paddr == `WDT_ADDR_CONTROL) begin
      d.sw_en        = pwdata[`WDT_SWEN_BIT];
      d.timeout_flag = pwdata[`WDT_TIMEOUT_BIT];
      d.sleep_flag   = pwdata[`WDT_SLEEP_BIT];
      d.idle_flag    = pwdata[`WDT_IDLE_BIT];
      d.src_sel      = pwdata[1:0];
    end
    if (wr && paddr == `WDT_ADDR_CONFIG) begin
      d.cfg = pwdata[7:0];
    end
    if (wr && paddr == `WDT_ADDR_IRQ_MASK) begin
      d.irq_mask = pwdata[1:0];
    end
    if (evt_timeout) begin
      d.timeout_flag = 1'b1;
    end
    if (power_save_instr && !in_save) begin
      d.sleep_flag = ~power_save_idle;
      d.idle_flag  = power_save_idle;
    end

    // Sticky status cleared by read; set wins
    // A read and an event in one cycle keep the event for the next read
    evt_vec = {evt_wake, evt_timeout};
    if (rd && paddr == `WDT_ADDR_IRQ_STATUS) begin
      d.irq_stat = evt_vec;
    end else begin
      d.irq_stat = q.irq_stat | evt_vec;
    end

    // APB answer: ready one cycle into the access phase, one wait state
    // Read data stands only while ready is high, zero otherwise
    d.pready  = access & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata  = '0;
    if (access && !q.pready) begin
      unique case (paddr)
        `WDT_ADDR_CONFIG:     d.prdata = {24'h00_0000, q.cfg};
        `WDT_ADDR_CONTROL:    d.prdata = {26'h000_0000, q.sw_en, q.timeout_flag,
                                          q.sleep_flag, q.idle_flag, q.src_sel};
        `WDT_ADDR_IRQ_STATUS: d.prdata = {30'h0000_0000, q.irq_stat};
        `WDT_ADDR_IRQ_MASK:   d.prdata = {30'h0000_0000, q.irq_mask};
        `WDT_ADDR_COUNT:      d.prdata = {9'h000, q.pre_cnt, q.post_cnt};
        default:              d.pslverr = 1'b1;
      endcase
    end

    // Registered outputs
    // Every output leaves from a flip-flop, never from the decode above
    d.rst_req = evt_timeout;
    d.src_en  = enabled;
    d.src_out = (in_save && q.pmode == PM_SLEEP) ? `WDT_SRC_RC_OSC : q.src_sel;
    d.irq     = |(d.irq_stat & q.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Device reset clears software enable and counters
  // Reset assigns constants only; the synchronisers clear alongside
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q          <= '0;
      q.cfg      <= `WDT_CONFIG_RESET;
      q.irq_mask <= `WDT_MASK_RESET;
      q.pmode    <= PM_RUN;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign prdata               = q.prdata;
  assign pready               = q.pready;
  assign pslverr              = q.pslverr;
  assign wake_request         = q.wake;
  assign device_reset_request = q.rst_req;
  assign clock_source_enable  = q.src_en;
  assign clock_source_select  = q.src_out;
  assign irq                  = q.irq;

endmodule : wdt_top
`default_nettype wire

// ### sim/wdt_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches bus answers and the reset and wake pulses
module wdt_top_assertions (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        power_save_instr,
  input wire logic        power_save_idle,
  input wire logic        clock_switch_done,
  input wire logic        wake_request,
  input wire logic        device_reset_request,
  input wire logic        clock_source_enable,
  input wire logic [1:0]  clock_source_select
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // One wait state; error only off the map
  property p_ack; psel && penable && !pready |=> pready; endproperty
  a_ack: assert property (p_ack) else $error("late ready");
  property p_err;
    pready |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010});
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  // Reset pulse single and only when enabled; wake and reset exclusive
  property p_rst; device_reset_request |=> !device_reset_request; endproperty
  a_rst: assert property (p_rst) else $error("long reset");
  property p_excl; wake_request |-> !device_reset_request; endproperty
  a_excl: assert property (p_excl) else $error("wake and reset");
  property p_en; device_reset_request |-> $past(clock_source_enable); endproperty
  a_en: assert property (p_en) else $error("reset while off");
  // Sleep uses the RC clock; entry and switch restart the count
  property p_src; power_save_instr && !power_save_idle |-> ##[1:3] clock_source_select == 2'h0;
  endproperty
  a_src: assert property (p_src) else $error("no RC in sleep");
  property p_ps; power_save_instr |-> ##2 !wake_request [*6]; endproperty
  a_ps: assert property (p_ps) else $error("wake after entry");
  property p_sw; clock_switch_done |-> ##2 !device_reset_request [*6]; endproperty
  a_sw: assert property (p_sw) else $error("reset after switch");
endmodule : wdt_top_assertions
bind wdt_top wdt_top_assertions wdt_top_assertions_i (.*);
`default_nettype wire

// ### sim/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: instructions are one-cycle pulses after an edge
module core_model (
  input  wire logic clk_sys,
  output logic      clear_watchdog_instr = 1'b0,
  output logic      power_save_instr     = 1'b0,
  output logic      power_save_idle      = 1'b0,
  output logic      clock_switch_done    = 1'b0
);
  ////////////////////////////////////////
  // k = {clear, power save, switch}; idle level kept
  task automatic issue(input logic [2:0] k, input logic idle);
    @(posedge clk_sys);
    {clear_watchdog_instr, power_save_instr, clock_switch_done} <= k;
    power_save_idle <= idle;
    @(posedge clk_sys);
    {clear_watchdog_instr, power_save_instr, clock_switch_done} <= 3'h0;
  endtask : issue
endmodule : core_model
`default_nettype wire

// ### sim/wdt_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module wdt_top_tb_top;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        low_power_rc_clock = 1'b0, secondary_oscillator = 1'b0, system_timer_clock = 1'b0;
  logic        pready, pslverr, wake_request, device_reset_request, clock_source_enable, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [1:0]  clock_source_select;
  wire logic   clear_watchdog_instr, power_save_instr, power_save_idle, clock_switch_done;
  int          miscompares = 0, tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  // Oscillators free-run off the clock edges, all slower than half the system clock
  initial begin
    #5;
    fork
      forever #50 low_power_rc_clock = ~low_power_rc_clock;
      forever #70 secondary_oscillator = ~secondary_oscillator;
      forever #90 system_timer_clock = ~system_timer_clock;
    join
  end
  wdt_top wdt_top_i (.*);
  core_model core_model_i (.*);
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("ready", 32'h1, 32'(n < 20));
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("reg %h", a), x, r & m);
  endtask : rd
  // Cycles until wake (w) or reset pulse, capped
  task automatic wev(input logic w, input int lim, output int n);
    n = 0;
    while ((w ? wake_request : device_reset_request) !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wev
  ////////////////////////////////////////
  task automatic t_en;
    logic [31:0] r;
    logic        e;
    rd(12'h000, 32'hFF, 32'hFF);
    rd(12'h004, 32'h3F, 32'h0);
    apb(1'b0, 12'h014, 32'h0, r, e);
    chk("unmapped", 32'h1, 32'(e));
    for (int k = 0; k < 8; k++) begin
      wr(12'h000, {24'h0, 1'b1, k[2:1], 5'h1F});
      wr(12'h004, {26'h0, k[0], 5'h00});
      repeat (3) @(posedge clk_sys);
      chk("enable", 32'(k[2:1] == 3 || (k[2:1] == 2 && k[0])), 32'(clock_source_enable));
    end
    $display("test enable done");
  endtask : t_en
  task automatic t_to(input logic [7:0] c, input int x);
    int n;
    wr(12'h000, 32'(c));
    wr(12'h00C, 32'h1);
    core_model_i.issue(3'b100, 1'b0);
    wev(1'b0, 2000, n);
    chk("timeout", 32'h1, 32'(n > x - 14 && n < x + 12));
    rd(12'h004, 32'h10, 32'h10);
    chk("irq", 32'h1, 32'(irq));
    rd(12'h008, 32'h1, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk("irq clear", 32'h0, 32'(irq));
    wr(12'h004, 32'h0);
    $display("test timeout %h done", c);
  endtask : t_to
  task automatic t_win;
    int n;
    wr(12'h00C, 32'h0);
    wr(12'h000, 32'h62);
    core_model_i.issue(3'b001, 1'b0);
    repeat (20) @(posedge clk_sys);
    core_model_i.issue(3'b100, 1'b0);
    wev(1'b0, 8, n);
    chk("early clear", 32'h1, 32'(n < 8));
    repeat (3) @(posedge clk_sys);
    chk("masked irq", 32'h0, 32'(irq));
    core_model_i.issue(3'b001, 1'b0);
    repeat (560) @(posedge clk_sys);
    core_model_i.issue(3'b100, 1'b0);
    wev(1'b0, 400, n);
    chk("late clear", 32'h1, 32'(n == 400));
    $display("test window done");
  endtask : t_win
  task automatic t_slp(input logic i);
    int n;
    wr(12'h000, 32'hE0);
    wr(12'h004, 32'h1);
    core_model_i.issue(3'b001, 1'b0);
    core_model_i.issue(3'b010, i);
    repeat (3) @(posedge clk_sys);
    chk("source", 32'(i), 32'(clock_source_select));
    wev(1'b1, 600, n);
    chk("wake", 32'h1, 32'(n > (i ? 205 : 142) && n < (i ? 240 : 176)));
    rd(12'h004, 32'hC, i ? 32'h4 : 32'h8);
    rd(12'h008, 32'h2, 32'h2);
    wr(12'h004, 32'h0);
    $display("test sleep %0d done", i);
  endtask : t_slp
  // Mid-run device reset clears software enable and the postscale count
  task automatic t_rst;
    wr(12'h004, 32'h20);
    wr(12'h000, 32'hE1);
    core_model_i.issue(3'b100, 1'b0);
    repeat (200) @(posedge clk_sys);
    rd(12'h010, 32'hFFFF, 32'h1);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(12'h004, 32'h3F, 32'h0);
    rd(12'h010, 32'hFFFF, 32'h0);
    rd(12'h000, 32'hFF, 32'hFF);
    $display("test reset done");
  endtask : t_rst
  task automatic stop_test;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_en;
    t_to(8'hE0, 160);
    t_to(8'hE1, 320);
    t_to(8'hF0, 640);
    t_win;
    t_slp(1'b0);
    t_slp(1'b1);
    t_rst;
    stop_test;
  end
  // Hang guard, about two and a half times the expected run
  initial begin
    #150_000;
    miscompares++;
    stop_test;
  end
endmodule : wdt_top_tb_top
`default_nettype wire
